// [verilog/vectored_interrupt_router.sv]
// vectored interrupt router: 54 sources to a normal and a fast request
// assumes INT_SRC on CLK; EXT_IRQ and GPIO_PIN are asynchronous pins
`timescale 1ns/10ps
`default_nettype none

module vectored_interrupt_router
(
	input  wire logic                       CLK,
	input  wire logic                       RST_N,
	input  wire logic [7:0]                 AVS_ADDRESS,
	input  wire logic                       AVS_READ,
	input  wire logic                       AVS_WRITE,
	input  wire logic [31:0]                AVS_WRITEDATA,
	input  wire logic [3:0]                 AVS_BYTEENABLE,
	output var  logic [31:0]                AVS_READDATA,
	output logic                            AVS_WAITREQUEST,
	input  wire logic [vir_pkg::NSRC-1:0]   INT_SRC,
	input  wire logic [vir_pkg::NEXT-1:0]   EXT_IRQ,
	input  wire logic [vir_pkg::NGPIO-1:0]  GPIO_PIN,
	output var  logic                       NORMAL_IRQ,
	output var  logic                       FAST_INTERRUPT_REQUEST,
	output var  vir_pkg::irq_vec_s          IRQ_VECTOR,
	output logic                            GPIO_IRQ
);

	logic                      ack_r;
	logic [31:0]               rd_w;
	logic [31:0]               wm_w;
	logic                      wr_go;
	logic [vir_pkg::NSRC-1:0]  en_r;
	logic [vir_pkg::NSRC-1:0]  fast_r;
	logic [vir_pkg::NSRC-1:0]  pol_r;
	logic [vir_pkg::NGPIO-1:0] gen_r;
	logic [vir_pkg::NGPIO-1:0] gedge_r;
	logic [vir_pkg::NGPIO-1:0] gpol_r;
	logic [vir_pkg::NGPIO-1:0] gboth_r;
	logic [vir_pkg::NGPIO-1:0] gstat_r;
	logic [vir_pkg::NGPIO-1:0] gstat_nxt;
	logic                      mask_n_r;
	logic                      mask_f_r;
	logic                      mask_l_r;
	logic [vir_pkg::SRC_W-1:0] thr_r;
	logic [7:0]                flvl_r [2];
	logic [7:0]                slot_r [vir_pkg::NSLOT];
	logic [vir_pkg::NPIN-1:0]  s1_r;
	logic [vir_pkg::NPIN-1:0]  s2_r;
	logic [vir_pkg::NPIN-1:0]  s3_r;
	logic [vir_pkg::NPIN-1:0]  filt_r;
	logic [vir_pkg::NPIN-1:0]  prev_r;
	logic [vir_pkg::NEXT-1:0]  ext_f;
	logic [vir_pkg::NGPIO-1:0] gp_f;
	logic [vir_pkg::NGPIO-1:0] gp_p;
	logic [vir_pkg::NSRC-1:0]  pend_w;
	logic [63:0]               npend_w;
	logic [63:0]               fpend_w;
	logic [63:0]               slotted_w;
	logic [vir_pkg::NSLOT-1:0] slot_hit;
	logic [vir_pkg::NSLOT-1:0] slot_ok;
	logic [1:0]                lvl_hit;
	logic                      irq_nxt;
	logic                      fiq_nxt;
	vir_pkg::irq_vec_s         vec_nxt;

	// bus slave: one wait cycle, read data registered in it
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
	assign wr_go = AVS_WRITE & ack_r;
	assign wm_w = vir_pkg::be_merge(rd_w, AVS_WRITEDATA, AVS_BYTEENABLE);

	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			ack_r <= 1'b0;
		else
			ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;

	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			AVS_READDATA <= 32'h0;
		else if (AVS_READ && !ack_r)
			AVS_READDATA <= rd_w;

	always_comb
	begin
		rd_w = 32'h0;
		if (AVS_ADDRESS[vir_pkg::SLOT_SEL_BIT])
			rd_w[7:0] = slot_r[AVS_ADDRESS[6:2]];
		else
			case (AVS_ADDRESS)
			vir_pkg::OFS_ENABLE_LO: rd_w = en_r[31:0];
			vir_pkg::OFS_ENABLE_HI: rd_w[vir_pkg::HI_W-1:0] = en_r[53:32];
			vir_pkg::OFS_ROUTE_LO:  rd_w = fast_r[31:0];
			vir_pkg::OFS_ROUTE_HI:  rd_w[vir_pkg::HI_W-1:0] = fast_r[53:32];
			vir_pkg::OFS_POL_LO:    rd_w = pol_r[31:0];
			vir_pkg::OFS_POL_HI:    rd_w[vir_pkg::HI_W-1:0] = pol_r[53:32];
			vir_pkg::OFS_PEND_LO:   rd_w = pend_w[31:0];
			vir_pkg::OFS_PEND_HI:   rd_w[vir_pkg::HI_W-1:0] = pend_w[53:32];
			vir_pkg::OFS_GPIO_EN:   rd_w[vir_pkg::NGPIO-1:0] = gen_r;
			vir_pkg::OFS_GPIO_EDGE: rd_w[vir_pkg::NGPIO-1:0] = gedge_r;
			vir_pkg::OFS_GPIO_POL:  rd_w[vir_pkg::NGPIO-1:0] = gpol_r;
			vir_pkg::OFS_GPIO_BOTH: rd_w[vir_pkg::NGPIO-1:0] = gboth_r;
			vir_pkg::OFS_GPIO_STAT: rd_w[vir_pkg::NGPIO-1:0] = gstat_r;
			vir_pkg::OFS_PRIO_MASK:
			begin
				rd_w[vir_pkg::MASK_NORM_BIT] = mask_n_r;
				rd_w[vir_pkg::MASK_FAST_BIT] = mask_f_r;
				rd_w[vir_pkg::MASK_LVL1_BIT] = mask_l_r;
				rd_w[vir_pkg::THR_LSB +: vir_pkg::SRC_W] = thr_r;
			end
			vir_pkg::OFS_FAST_LVL0: rd_w[7:0] = flvl_r[0];
			vir_pkg::OFS_FAST_LVL1: rd_w[7:0] = flvl_r[1];
			vir_pkg::OFS_VECTOR:    rd_w[$bits(IRQ_VECTOR)-1:0] = IRQ_VECTOR;
			default:                rd_w = 32'h0;
			endcase
	end

	// source configuration: enable, route, polarity
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			en_r   <= '0;
			fast_r <= '0;
			pol_r  <= '0;
		end
		else if (wr_go && !AVS_ADDRESS[vir_pkg::SLOT_SEL_BIT])
			case (AVS_ADDRESS)
			vir_pkg::OFS_ENABLE_LO: en_r[31:0] <= wm_w;
			vir_pkg::OFS_ENABLE_HI: en_r[53:32] <= wm_w[vir_pkg::HI_W-1:0];
			vir_pkg::OFS_ROUTE_LO:  fast_r[31:0] <= wm_w;
			vir_pkg::OFS_ROUTE_HI:  fast_r[53:32] <= wm_w[vir_pkg::HI_W-1:0];
			vir_pkg::OFS_POL_LO:    pol_r[31:0] <= wm_w;
			vir_pkg::OFS_POL_HI:    pol_r[53:32] <= wm_w[vir_pkg::HI_W-1:0];
			default:                ;
			endcase

	// pin configuration and priority controls
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			gen_r    <= '0;
			gedge_r  <= '0;
			gpol_r   <= '0;
			gboth_r  <= '0;
			mask_n_r <= 1'b0;
			mask_f_r <= 1'b0;
			mask_l_r <= 1'b0;
			thr_r    <= vir_pkg::THR_RESET;
			flvl_r   <= '{default: 8'h00};
		end
		else if (wr_go && !AVS_ADDRESS[vir_pkg::SLOT_SEL_BIT])
			case (AVS_ADDRESS)
			vir_pkg::OFS_GPIO_EN:   gen_r <= wm_w[vir_pkg::NGPIO-1:0];
			vir_pkg::OFS_GPIO_EDGE: gedge_r <= wm_w[vir_pkg::NGPIO-1:0];
			vir_pkg::OFS_GPIO_POL:  gpol_r <= wm_w[vir_pkg::NGPIO-1:0];
			vir_pkg::OFS_GPIO_BOTH: gboth_r <= wm_w[vir_pkg::NGPIO-1:0];
			vir_pkg::OFS_PRIO_MASK:
			begin
				mask_n_r <= wm_w[vir_pkg::MASK_NORM_BIT];
				mask_f_r <= wm_w[vir_pkg::MASK_FAST_BIT];
				mask_l_r <= wm_w[vir_pkg::MASK_LVL1_BIT];
				thr_r    <= wm_w[vir_pkg::THR_LSB +: vir_pkg::SRC_W];
			end
			vir_pkg::OFS_FAST_LVL0: flvl_r[0] <= wm_w[7:0] & 8'hbf;
			vir_pkg::OFS_FAST_LVL1: flvl_r[1] <= wm_w[7:0] & 8'hbf;
			default:                ;
			endcase

	// slot table; bit 6 is reserved and kept zero
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			slot_r <= '{default: 8'h00};
		else if (wr_go && AVS_ADDRESS[vir_pkg::SLOT_SEL_BIT])
			slot_r[AVS_ADDRESS[6:2]] <= wm_w[7:0] & 8'hbf;

	// pin synchroniser: a change counts once stages two and three agree
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			s1_r   <= '0;
			s2_r   <= '0;
			s3_r   <= '0;
			filt_r <= '0;
			prev_r <= '0;
		end
		else
		begin
			s1_r   <= {GPIO_PIN, EXT_IRQ};
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
			prev_r <= filt_r;
		end

	assign ext_f = filt_r[vir_pkg::NEXT-1:0];
	assign gp_f  = filt_r[vir_pkg::NPIN-1:vir_pkg::NEXT];
	assign gp_p  = prev_r[vir_pkg::NPIN-1:vir_pkg::NEXT];

	// pin status: level modes follow the pin, edge modes are sticky and
	// cleared by writing one; a new edge beats the clear
	always_comb
	begin
		gstat_nxt = gstat_r;
		if (wr_go && AVS_ADDRESS == vir_pkg::OFS_GPIO_STAT)
			gstat_nxt = gstat_r & ~wm_w[vir_pkg::NGPIO-1:0];
		for (int g = 0; g < vir_pkg::NGPIO; g++)
			if (!gedge_r[g])
				gstat_nxt[g] = gp_f[g] == gpol_r[g];
			else if (gp_f[g] != gp_p[g] &&
				(gboth_r[g] || gp_f[g] == gpol_r[g]))
				gstat_nxt[g] = 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			gstat_r <= '0;
		else
			gstat_r <= gstat_nxt;

	assign GPIO_IRQ = |(gstat_r & gen_r);

	// per-source pending level
	always_comb
	begin
		pend_w = INT_SRC ^ pol_r;
		pend_w[vir_pkg::EXT_SRC0] = ext_f[0];
		pend_w[vir_pkg::EXT_SRC1] = ext_f[1];
		pend_w[vir_pkg::EXT_SRC2] = ext_f[2];
		pend_w[vir_pkg::GPIO_SRC] = GPIO_IRQ;
	end

	assign npend_w = {10'h0, pend_w & en_r & ~fast_r};
	assign fpend_w = {10'h0, pend_w & en_r & fast_r};

	// slot lookup; unslotted normal sources rank below every slot
	always_comb
	begin
		slotted_w = '0;
		slot_hit  = '0;
		slot_ok   = '0;
		for (int s = 0; s < vir_pkg::NSLOT; s++)
		begin
			if (slot_r[s][vir_pkg::SLOT_VALID_BIT])
				slotted_w[slot_r[s][5:0]] = 1'b1;
			slot_hit[s] = slot_r[s][vir_pkg::SLOT_VALID_BIT] &
				npend_w[slot_r[s][5:0]];
			slot_ok[s] = slot_hit[s] && s < 32'(thr_r);
		end
		for (int l = 0; l < 2; l++)
			lvl_hit[l] = flvl_r[l][vir_pkg::SLOT_VALID_BIT] &
				fpend_w[flvl_r[l][5:0]];
	end

	always_comb
	begin
		vec_nxt = '0;
		irq_nxt = ~mask_n_r & ((|slot_ok) |
			(thr_r >= vir_pkg::THR_RESET &&
			|(npend_w & ~slotted_w)));
		for (int s = vir_pkg::NSLOT - 1; s >= 0; s--)
			if (slot_ok[s] && !mask_n_r)
			begin
				vec_nxt.valid  = 1'b1;
				vec_nxt.slot   = 5'(s);
				vec_nxt.source = slot_r[s][5:0];
			end
		fiq_nxt = ~mask_f_r & (lvl_hit[0] | (~mask_l_r & (lvl_hit[1] |
			|(fpend_w & ~({63'h0, flvl_r[0][7]} << flvl_r[0][5:0])
			& ~({63'h0, flvl_r[1][7]} << flvl_r[1][5:0])))));
		vec_nxt.fast_valid = ~mask_f_r &
			(lvl_hit[0] | (lvl_hit[1] & ~mask_l_r));
		vec_nxt.fast_level = ~lvl_hit[0];
	end

	// outputs to the core are registered to keep them glitch free
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			NORMAL_IRQ             <= 1'b0;
			FAST_INTERRUPT_REQUEST <= 1'b0;
			IRQ_VECTOR             <= '0;
		end
		else
		begin
			NORMAL_IRQ             <= irq_nxt;
			FAST_INTERRUPT_REQUEST <= fiq_nxt;
			IRQ_VECTOR             <= vec_nxt;
		end

	a_none_enabled: assert property (@(posedge CLK) disable iff (!RST_N)
		en_r == '0 |=> !NORMAL_IRQ && !FAST_INTERRUPT_REQUEST)
		else $error("output raised with no source enabled");

	a_normal_route: assert property (@(posedge CLK) disable iff (!RST_N)
		(|npend_w) && !mask_n_r && thr_r == vir_pkg::THR_RESET
		|=> NORMAL_IRQ)
		else $error("normal request not raised");

	a_fast_route: assert property (@(posedge CLK) disable iff (!RST_N)
		(|fpend_w) && !mask_f_r && !mask_l_r |=> FAST_INTERRUPT_REQUEST)
		else $error("fast request not raised");

	a_mask_all: assert property (@(posedge CLK) disable iff (!RST_N)
		mask_n_r && mask_f_r |=> !NORMAL_IRQ && !FAST_INTERRUPT_REQUEST)
		else $error("masked request reached the core");

	a_slot_first: assert property (@(posedge CLK) disable iff (!RST_N)
		slot_hit[0] && !mask_n_r && thr_r != '0
		|=> IRQ_VECTOR.valid && IRQ_VECTOR.slot == '0 && NORMAL_IRQ)
		else $error("slot zero not reported first");

	a_fast_level: assert property (@(posedge CLK) disable iff (!RST_N)
		lvl_hit[0] && !mask_f_r
		|=> FAST_INTERRUPT_REQUEST && IRQ_VECTOR.fast_level == 1'b0)
		else $error("fast level zero not reported");

	a_polarity: assert property (@(posedge CLK) disable iff (!RST_N)
		en_r[0] && !fast_r[0] && !mask_n_r &&
		thr_r == vir_pkg::THR_RESET && (INT_SRC[0] != pol_r[0])
		|=> NORMAL_IRQ)
		else $error("internal source polarity wrong");

	a_pin_rise: assert property (@(posedge CLK) disable iff (!RST_N)
		gedge_r[0] && gpol_r[0] && !gboth_r[0] && gp_f[0] && !gp_p[0]
		|=> gstat_r[0])
		else $error("rising pin edge lost");

	a_ext_map: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(EXT_IRQ[2]) ##1 EXT_IRQ[2] [*3]
		|=> pend_w[vir_pkg::EXT_SRC2])
		else $error("expansion line seven not on source 40");

	a_bus_answer: assert property (@(posedge CLK) disable iff (!RST_N)
		AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("waitrequest held longer than one cycle");

endmodule

`default_nettype wire

// [pkg/vir_pkg.sv]
// constants, register map and carrier types of the vectored interrupt router
// assumes a single 100 MHz clock and an Avalon-MM slave with byte addresses
//
// Functional notes
// - accept 54 distinct sources, each able to raise a request.
// - each source routes to either the normal or the fast output.
// - thirty-two priority slots, each holding a source, vector normal requests.
// - two priority levels vector fast requests.
// - internal sources are level sensitive, active high or active low.
// - pin interrupts: high level, low level, rising, falling or both edges.
// - three dedicated off-chip lines are active-high level requests.
// - each of nineteen general pins can be enabled as interrupt source.
// - software priority mask covers all normal and all fast requests.
// - expansion lines five, six, seven feed sources 22, 33, 40.
package vir_pkg;

	localparam int NSRC   = 54;
	localparam int NGPIO  = 19;
	localparam int NEXT   = 3;
	localparam int NSLOT  = 32;
	localparam int NPIN   = NEXT + NGPIO;
	localparam int SRC_W  = 6;
	localparam int SLOT_W = 5;
	localparam int HI_W   = NSRC - 32;

	// source numbers of the off-chip lines and of the pin aggregate
	localparam logic [SRC_W-1:0] EXT_SRC0 = 6'h16;
	localparam logic [SRC_W-1:0] EXT_SRC1 = 6'h21;
	localparam logic [SRC_W-1:0] EXT_SRC2 = 6'h28;
	localparam logic [SRC_W-1:0] GPIO_SRC = 6'h35;

	// byte offsets of the register map
	localparam logic [7:0] OFS_ENABLE_LO = 8'h00;
	localparam logic [7:0] OFS_ENABLE_HI = 8'h04;
	localparam logic [7:0] OFS_ROUTE_LO  = 8'h08;
	localparam logic [7:0] OFS_ROUTE_HI  = 8'h0c;
	localparam logic [7:0] OFS_POL_LO    = 8'h10;
	localparam logic [7:0] OFS_POL_HI    = 8'h14;
	localparam logic [7:0] OFS_PEND_LO   = 8'h18;
	localparam logic [7:0] OFS_PEND_HI   = 8'h1c;
	localparam logic [7:0] OFS_GPIO_EN   = 8'h20;
	localparam logic [7:0] OFS_GPIO_EDGE = 8'h24;
	localparam logic [7:0] OFS_GPIO_POL  = 8'h28;
	localparam logic [7:0] OFS_GPIO_BOTH = 8'h2c;
	localparam logic [7:0] OFS_GPIO_STAT = 8'h30;
	localparam logic [7:0] OFS_PRIO_MASK = 8'h34;
	localparam logic [7:0] OFS_FAST_LVL0 = 8'h38;
	localparam logic [7:0] OFS_FAST_LVL1 = 8'h3c;
	localparam logic [7:0] OFS_VECTOR    = 8'h40;
	localparam int         SLOT_SEL_BIT  = 7;

	// field positions
	localparam int SLOT_VALID_BIT = 7;
	localparam int MASK_NORM_BIT  = 0;
	localparam int MASK_FAST_BIT  = 1;
	localparam int MASK_LVL1_BIT  = 2;
	localparam int THR_LSB        = 8;
	localparam logic [SRC_W-1:0] THR_RESET = 6'h20;

	typedef struct packed {
		logic              valid;
		logic [SLOT_W-1:0] slot;
		logic [SRC_W-1:0]  source;
		logic              fast_valid;
		logic              fast_level;
	} irq_vec_s;

	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		return r;
	endfunction

endpackage

// [verif/core_model.sv]
// behavioural processor core: counts one take per cycle in which a normal or fast request rises
// assumes registered request levels on the router clock
`timescale 1ns/10ps
`default_nettype none

module core_model
(
	input  wire logic CLK,
	input  wire logic RST_N,
	input  wire logic NORMAL_IRQ,
	input  wire logic FAST_INTERRUPT_REQUEST,
	output var  int   takes
);
	logic n_r;
	logic f_r;

	// a level that stays up is one request, so only rises are counted
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			n_r   <= 1'h0;
			f_r   <= 1'h0;
			takes <= 0;
		end
		else
		begin
			n_r <= NORMAL_IRQ;
			f_r <= FAST_INTERRUPT_REQUEST;
			if ((NORMAL_IRQ && !n_r) || (FAST_INTERRUPT_REQUEST && !f_r))
				takes <= takes + 1;
		end
	end
endmodule

`default_nettype wire

// [verif/vectored_interrupt_router_tb_top.sv]
// self-checking bench of the vectored interrupt router
// assumes the package and core model compile first; one 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin \
	failures++; $display("mismatch t=%0t %s", $time, m); end end

module vectored_interrupt_router_tb_top;
	// f = {level, active low, fast route, enable, want normal, want fast}
	typedef struct packed {logic [5:0] src; logic [5:0] f;} row_s;
	// m = {idle, active, edge, high or rising, both edges}
	typedef struct packed {logic [4:0] m; logic [4:0] pin;} pin_s;
	logic              clk = 1'h0;
	logic              rst_n = 1'h0;
	logic [7:0]        addr = 8'h00;
	logic              rd = 1'h0;
	logic              wr = 1'h0;
	logic [31:0]       wdata = 32'h0;
	logic [31:0]       rdata;
	logic              wait_req;
	logic [53:0]       int_src = 54'h0;
	logic [2:0]        ext_irq = 3'h0;
	logic [18:0]       gpio_pin = 19'h0;
	logic              norm;
	logic              fast;
	logic              gpio_irq;
	vir_pkg::irq_vec_s vec;
	int                failures = 0;
	int                checks = 0;
	int                cyc = 0;
	int                takes;
	logic [31:0]       q;
	logic [53:0]       oh;
	logic [31:0]       b;
	logic [5:0]        xs [3] = '{vir_pkg::EXT_SRC0, vir_pkg::EXT_SRC1,
		vir_pkg::EXT_SRC2};
	row_s rows [5] = '{
		'{6'h00, 6'h26},  // plain normal
		'{6'h1f, 6'h2d},  // routed fast
		'{6'h20, 6'h16},  // active low at level 0
		'{6'h34, 6'h20},  // disabled source
		'{6'h15, 6'h04}}; // enabled, idle
	pin_s pins [5] = '{'{5'h0a, 5'd9}, '{5'h10, 5'd4}, '{5'h0e, 5'd0},
		'{5'h14, 5'd13}, '{5'h15, 5'd18}};

	vectored_interrupt_router vectored_interrupt_router_inst (
		.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
		.INT_SRC(int_src), .EXT_IRQ(ext_irq), .GPIO_PIN(gpio_pin),
		.NORMAL_IRQ(norm), .FAST_INTERRUPT_REQUEST(fast),
		.IRQ_VECTOR(vec), .GPIO_IRQ(gpio_irq));

	core_model core_model_inst (.CLK(clk), .RST_N(rst_n),
		.NORMAL_IRQ(norm), .FAST_INTERRUPT_REQUEST(fast), .takes(takes));

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one access; an edge always passes first so strobes never retoggle
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wr    <= w;
		rd    <= ~w;
		wdata <= d;
		do
			@(posedge clk);
		while (wait_req !== 1'h0);
		q = rdata;
		wr <= 1'h0;
		rd <= 1'h0;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic cfg(input logic [53:0] e, input logic [53:0] r,
		input logic [53:0] p);
		bus(1'h1, vir_pkg::OFS_ENABLE_LO, e[31:0]);
		bus(1'h1, vir_pkg::OFS_ENABLE_HI, {10'h0, e[53:32]});
		bus(1'h1, vir_pkg::OFS_ROUTE_LO, r[31:0]);
		bus(1'h1, vir_pkg::OFS_ROUTE_HI, {10'h0, r[53:32]});
		bus(1'h1, vir_pkg::OFS_POL_LO, p[31:0]);
		bus(1'h1, vir_pkg::OFS_POL_HI, {10'h0, p[53:32]});
	endtask

	initial
	begin
		wt(2);
		rst_n <= 1'h1;
		@(negedge clk);
		`CHK({norm, fast, vec, gpio_irq}, 17'h0, "outputs after reset")
		bus(1'h0, vir_pkg::OFS_PRIO_MASK, 32'h0);
		`CHK(q, 32'h00002000, "mask reset value")
		bus(1'h1, 8'h44, 32'hffffffff);
		bus(1'h0, 8'h44, 32'h0);
		`CHK(q, 32'h0, "unmapped read")
		bus(1'h1, vir_pkg::OFS_PEND_LO, 32'hffffffff);
		bus(1'h0, vir_pkg::OFS_PEND_LO, 32'h0);
		`CHK(q, 32'h0, "pending is read-only")
		$display("test reset done");
		foreach (rows[i])
		begin
			oh = 54'h1 << rows[i].src;
			cfg(rows[i].f[2] ? oh : 54'h0, rows[i].f[3] ? oh : 54'h0,
				rows[i].f[4] ? oh : 54'h0);
			int_src <= rows[i].f[5] ? oh : 54'h0;
			wt(3);
			`CHK(norm, rows[i].f[1], "normal output")
			`CHK(fast, rows[i].f[0], "fast output")
		end
		$display("test table done");
		cfg(54'h220, 54'h0, 54'h0);
		bus(1'h1, 8'h80, 32'h85);
		bus(1'h1, 8'h8c, 32'h89);
		int_src <= 54'h220;
		wt(3);
		`CHK({vec.valid, vec.slot, vec.source}, 12'h805, "slot 0 wins")
		int_src <= 54'h200;
		wt(3);
		`CHK({vec.slot, vec.source}, 11'h0c9, "slot 3 vector")
		bus(1'h0, vir_pkg::OFS_VECTOR, 32'h0);
		`CHK(q, 32'h00002325, "vector register read")
		bus(1'h1, vir_pkg::OFS_PRIO_MASK, 32'h00000300);
		wt(3);
		`CHK(norm, 1'h0, "threshold masks slot 3")
		bus(1'h1, vir_pkg::OFS_PRIO_MASK, 32'h00000400);
		wt(3);
		`CHK(norm, 1'h1, "threshold above slot 3")
		bus(1'h1, vir_pkg::OFS_PRIO_MASK, 32'h00002001);
		wt(3);
		`CHK(norm, 1'h0, "all normal masked")
		bus(1'h1, vir_pkg::OFS_PRIO_MASK, 32'h00002000);
		$display("test slots done");
		cfg(54'hc0000000, 54'hc0000000, 54'h0);
		bus(1'h1, vir_pkg::OFS_FAST_LVL0, 32'h9f);
		bus(1'h1, vir_pkg::OFS_FAST_LVL1, 32'h9e);
		int_src <= 54'hc0000000;
		wt(3);
		`CHK({fast, vec.fast_valid, vec.fast_level}, 3'h6, "level 0")
		int_src <= 54'h40000000;
		wt(3);
		`CHK({fast, vec.fast_valid, vec.fast_level}, 3'h7, "level 1")
		bus(1'h1, vir_pkg::OFS_PRIO_MASK, 32'h00002004);
		wt(3);
		`CHK(fast, 1'h0, "level 1 masked")
		int_src <= 54'hc0000000;
		bus(1'h1, vir_pkg::OFS_PRIO_MASK, 32'h00002002);
		wt(3);
		`CHK(fast, 1'h0, "all fast masked")
		bus(1'h1, vir_pkg::OFS_PRIO_MASK, 32'h00002000);
		int_src <= 54'h0;
		$display("test fast done");
		for (int i = 0; i < 3; i++)
		begin
			cfg(54'h1 << xs[i], 54'h0, 54'h0);
			ext_irq <= 3'h1 << i; // one dedicated line at a time, held as a level
			wt(10);
			`CHK(norm, 1'h1, "off-chip line raised")
			ext_irq <= 3'h0;
			wt(10);
			`CHK(norm, 1'h0, "off-chip line dropped")
		end
		$display("test off-chip done");
		cfg(54'h1 << 53, 54'h0, 54'h0);
		foreach (pins[i])
		begin
			b = 32'h1 << pins[i].pin;
			gpio_pin <= {18'h0, pins[i].m[4]} << pins[i].pin;
			wt(10);
			bus(1'h1, vir_pkg::OFS_GPIO_EDGE, pins[i].m[2] ? b : 32'h0);
			bus(1'h1, vir_pkg::OFS_GPIO_POL, pins[i].m[1] ? b : 32'h0);
			bus(1'h1, vir_pkg::OFS_GPIO_BOTH, pins[i].m[0] ? b : 32'h0);
			bus(1'h1, vir_pkg::OFS_GPIO_EN, b);
			bus(1'h1, vir_pkg::OFS_GPIO_STAT, 32'h0007ffff);
			wt(2);
			`CHK({gpio_irq, norm}, 2'h0, "pin idle")
			gpio_pin[pins[i].pin] <= pins[i].m[3];
			wt(10);
			`CHK({gpio_irq, norm}, 2'h3, "pin active")
			bus(1'h1, vir_pkg::OFS_GPIO_STAT, b);
			wt(2);
			`CHK(gpio_irq, ~pins[i].m[2], "edge cleared, level kept")
		end
		$display("test pins done");
		`CHK(takes > 0, 1'h1, "core saw requests")
		rst_n <= 1'h0;
		wt(2);
		`CHK({norm, fast, vec, gpio_irq}, 17'h0, "outputs in reset")
		rst_n <= 1'h1;
		bus(1'h0, vir_pkg::OFS_GPIO_EN, 32'h0);
		`CHK(q, 32'h0, "pin enable after reset")
		$display("test reset again done");
		end_sim();
	end
endmodule

`default_nettype wire
